// ===== rtl/blk_fifo.sv
// Synchronous FIFO for scrambled blocks with a registered read stage.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module blk_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input wire logic clk_i, // Lane block clock
  input wire logic srst_i, // Synchronous reset
  blk_fifo_if.fifo port_if // Fill and drain sides
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic ready_ff, nxt_ready;
  logic oval_ff, nxt_oval;
  logic [WIDTH-1:0] odata_ff, nxt_odata;
  logic push, load;

  // ----------------------------------------------------------------------
  // Pointer, count and output stage
  // ----------------------------------------------------------------------
  // Ready is registered so the source sees a clean level; full is exact
  always_comb
  begin
    push = port_if.in_valid && ready_ff;
    load = (count_ff != '0) && (!oval_ff || port_if.out_ready);
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = load ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    nxt_ready = nxt_count < (AW+1)'(DEPTH);
    nxt_odata = load ? mem[rd_ptr_ff] : odata_ff;
    nxt_oval = load || (oval_ff && !port_if.out_ready);
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      ready_ff <= 1'b0;
      oval_ff <= 1'b0;
      odata_ff <= '0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      ready_ff <= nxt_ready;
      oval_ff <= nxt_oval;
      odata_ff <= nxt_odata;
    end
  end

  // Storage array, written only on an accepted push
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= port_if.in_data;
    end
  end

  assign port_if.in_ready = ready_ff;
  assign port_if.out_valid = oval_ff;
  assign port_if.out_data = odata_ff;
endmodule

// ===== rtl/blk_fifo_if.sv
// Carrier between the block FIFO and the stream generator.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface blk_fifo_if #(parameter int WIDTH = 64);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (input in_valid, input in_data, output in_ready,
    output out_valid, output out_data, input out_ready);
  modport user (output in_valid, output in_data, input in_ready,
    input out_valid, input out_data, output out_ready);
endinterface

// ===== rtl/shs_pkg.sv
// Constants for the sync header stream generator of one transmit lane.
// Assumes a single lane block clock; no software-visible registers.
package shs_pkg;

  // ----------------------------------------------------------------------
  // Block and multiblock geometry
  // ----------------------------------------------------------------------
  localparam int BLK_W = 64;
  localparam int TX_W = 66;
  localparam int IDX_W = 5;
  localparam int EMB_W = 8;
  localparam int STREAM_W = 32;
  localparam int PAR_W = 26;
  localparam int CRC_W = 12;
  localparam int FIFO_DEPTH = 32;
  localparam logic [4:0] LAST_BLK = 5'h1F;

  // ----------------------------------------------------------------------
  // Sync header codes, vector is {second bit, first bit}
  // ----------------------------------------------------------------------
  localparam logic [1:0] SH_ONE = 2'h2;
  localparam logic [1:0] SH_ZERO = 2'h1;

  // ----------------------------------------------------------------------
  // Format select codes and parity generators (top term implicit)
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_CRC12 = 2'h0;
  localparam logic [1:0] MODE_FEC = 2'h2;
  localparam logic [11:0] CRC_POLY = 12'h30F; // 0x130F with x^12 dropped
  localparam logic [25:0] FEC_POLY = 26'h0220211;

  // ----------------------------------------------------------------------
  // Stream word layout
  // ----------------------------------------------------------------------
  localparam logic [31:0] CRC_FIXED = 32'h80A8_8888;
  localparam logic [31:0] FEC_FIXED = 32'h8000_0000;
  localparam int EMB_FLAG_POS = 22;
  localparam int FEC_P3_POS = 23;
  localparam int FEC_LOW_POS = 24;
  localparam int PILOT_POS = 27;

  // Lane sequencing states
  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } flow_e;

endpackage

// ===== rtl/sync_header_stream_gen.sv
// Sync header stream generator for one 64B/66B transmit lane.
// Assumes scrambled blocks arrive in order and the extended multiblock
// clock input pulses once at each SYSREF-aligned extended multiblock start.
`timescale 1ns/1ps
module sync_header_stream_gen (
  input wire logic clk_i, // 20 MHz block clock
  input wire logic srst_i, // Synchronous reset, active high
  input wire logic blk_valid_i, // Scrambled block offered
  input wire logic [63:0] blk_data_i, // Scrambled block, bit 0 first
  output logic blk_ready_o, // FIFO can take a block
  input wire logic local_extended_multiblock_clock_i, // EMB start pulse
  input wire logic [1:0] sync_header_format_select_i, // 0 CRC, 2 FEC
  input wire logic [7:0] ext_mb_last_i, // E minus one
  output logic tx_valid_o, // Coded block valid
  output logic [65:0] tx_block_o, // Header in [1:0], data above
  input wire logic tx_ready_i, // Serializer takes the block
  output logic end_of_multiblock_pilot_o // Last block of a multiblock
);

  blk_fifo_if #(.WIDTH(shs_pkg::BLK_W)) fifo_if ();

  blk_fifo #(
    .WIDTH(shs_pkg::BLK_W),
    .DEPTH(shs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .port_if(fifo_if)
  );

  assign fifo_if.in_valid = blk_valid_i;
  assign fifo_if.in_data = blk_data_i;
  assign blk_ready_o = fifo_if.in_ready;

  // ----------------------------------------------------------------------
  // Parity and stream word helpers
  // ----------------------------------------------------------------------
  // One block through the serial divider, 64 steps unrolled per clock
  function automatic logic [25:0] par_step(input logic [25:0] s,
    input logic [63:0] d, input logic fec);
    logic [25:0] r;
    logic fb;
    r = s;
    for (int i = 0; i < shs_pkg::BLK_W; i++)
    begin
      fb = d[i] ^ (fec ? r[25] : r[11]);
      r = {r[24:0], 1'b0};
      if (fec)
      begin
        r = r ^ (fb ? shs_pkg::FEC_POLY : 26'h0000000);
      end
      else
      begin
        r = {14'h0000, r[11:0] ^ (fb ? shs_pkg::CRC_POLY : 12'h000)};
      end
    end
    return r;
  endfunction

  // Lay parity and flag into the 32-bit stream word
  function automatic logic [31:0] build_word(input logic [25:0] p,
    input logic fec, input logic emb_flag);
    logic [31:0] w;
    if (fec)
    begin
      w = shs_pkg::FEC_FIXED;
      for (int n = 0; n < 22; n++)
      begin
        w[n] = p[25-n];
      end
      w[shs_pkg::FEC_P3_POS] = p[3];
      for (int n = 0; n < 3; n++)
      begin
        w[shs_pkg::FEC_LOW_POS+n] = p[2-n];
      end
    end
    else
    begin
      w = shs_pkg::CRC_FIXED;
      for (int n = 0; n < shs_pkg::CRC_W; n++)
      begin
        w[n + n/3] = p[11-n];
      end
    end
    w[shs_pkg::EMB_FLAG_POS] = emb_flag;
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------------
  shs_pkg::flow_e st_ff, nxt_st;
  logic [4:0] blk_idx_ff, nxt_blk_idx;
  logic [7:0] emb_idx_ff, nxt_emb_idx;
  logic [25:0] par_ff, nxt_par;
  logic [31:0] stream_ff, nxt_stream;
  logic fec_ff, nxt_fec;
  logic tx_valid_ff, nxt_tx_valid;
  logic [65:0] tx_block_ff, nxt_tx_block;
  logic pilot_ff, nxt_pilot;
  logic adv, mb_end, restart, sel_fec;
  logic [7:0] emb_next;
  logic [25:0] blk_par;

  // Unsupported format codes fall back to CRC-12
  assign sel_fec = sync_header_format_select_i == shs_pkg::MODE_FEC;
  assign restart = local_extended_multiblock_clock_i;
  assign adv = (st_ff == shs_pkg::ST_RUN) && fifo_if.out_valid &&
    (!tx_valid_ff || tx_ready_i);
  assign mb_end = adv && (blk_idx_ff == shs_pkg::LAST_BLK);
  assign fifo_if.out_ready = (st_ff == shs_pkg::ST_RUN) &&
    (!tx_valid_ff || tx_ready_i);

  // Next-state logic: counters, parity, stream word and output stage
  always_comb
  begin
    nxt_st = st_ff;
    nxt_blk_idx = blk_idx_ff;
    nxt_emb_idx = emb_idx_ff;
    nxt_par = par_ff;
    nxt_stream = stream_ff;
    nxt_fec = fec_ff;
    nxt_tx_valid = tx_valid_ff && !tx_ready_i;
    nxt_tx_block = tx_block_ff;
    nxt_pilot = pilot_ff && !tx_ready_i;
    emb_next = (emb_idx_ff == ext_mb_last_i) ? 8'h00 : emb_idx_ff + 8'h01;
    // Each multiblock starts its divider from zero
    blk_par = par_step((blk_idx_ff == 5'h00) ? 26'h0000000 : par_ff,
      fifo_if.out_data, fec_ff);
    case (st_ff)
      shs_pkg::ST_WAIT:
      begin
        // No block leaves before the extended multiblock phase is known
        if (restart)
        begin
          nxt_st = shs_pkg::ST_RUN;
        end
      end
      shs_pkg::ST_RUN:
      begin
        if (adv)
        begin
          nxt_tx_valid = 1'b1;
          // Header goes ahead of the scrambled payload
          nxt_tx_block = {fifo_if.out_data,
            stream_ff[blk_idx_ff] ? shs_pkg::SH_ONE
                                  : shs_pkg::SH_ZERO};
          nxt_pilot = blk_idx_ff == shs_pkg::LAST_BLK;
          nxt_blk_idx = blk_idx_ff + 5'h01;
          nxt_par = blk_par;
        end
        if (mb_end)
        begin
          // Parity of this multiblock rides in the next one
          nxt_emb_idx = emb_next;
          nxt_stream = build_word(blk_par, fec_ff,
            emb_next == ext_mb_last_i);
          nxt_fec = sel_fec;
        end
      end
      default:
      begin
        nxt_st = shs_pkg::ST_WAIT;
      end
    endcase
    // Restart realigns counters; payload in flight is kept
    if (restart)
    begin
      nxt_blk_idx = 5'h00;
      nxt_emb_idx = 8'h00;
      nxt_par = 26'h0000000;
      nxt_fec = sel_fec;
      nxt_stream = build_word(26'h0000000, sel_fec,
        ext_mb_last_i == 8'h00);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_ff <= shs_pkg::ST_WAIT;
      blk_idx_ff <= 5'h00;
      emb_idx_ff <= 8'h00;
      par_ff <= 26'h0000000;
      stream_ff <= shs_pkg::CRC_FIXED;
      fec_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_block_ff <= 66'h0;
      pilot_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      blk_idx_ff <= nxt_blk_idx;
      emb_idx_ff <= nxt_emb_idx;
      par_ff <= nxt_par;
      stream_ff <= nxt_stream;
      fec_ff <= nxt_fec;
      tx_valid_ff <= nxt_tx_valid;
      tx_block_ff <= nxt_tx_block;
      pilot_ff <= nxt_pilot;
    end
  end

  assign tx_valid_o = tx_valid_ff;
  assign tx_block_o = tx_block_ff;
  assign end_of_multiblock_pilot_o = pilot_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Helper copies of the index and flag that belong to the emitted block
  logic [4:0] out_idx_ff;
  logic out_emb_flag_ff;
  logic out_bit_ff;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      out_idx_ff <= 5'h00;
      out_emb_flag_ff <= 1'b0;
      out_bit_ff <= 1'b0;
    end
    else if (adv)
    begin
      out_idx_ff <= blk_idx_ff;
      out_emb_flag_ff <= emb_idx_ff == ext_mb_last_i;
      out_bit_ff <= stream_ff[blk_idx_ff];
    end
  end

  sequence s_mb_end;
    adv && (blk_idx_ff == shs_pkg::LAST_BLK) && !restart;
  endsequence

  sequence s_first_zero;
    adv && (blk_idx_ff == 5'h00) && (fifo_if.out_data == 64'h0) &&
      !restart;
  endsequence

  a_sh_complement: assert property (@(posedge clk_i) disable iff (srst_i)
    tx_valid_o |-> tx_block_o[0] != tx_block_o[1])
    else $error("sync header bits equal");

  a_sh_bit_map: assert property (@(posedge clk_i) disable iff (srst_i)
    adv |=> tx_block_o[1:0] == (out_bit_ff ? 2'h2 : 2'h1))
    else $error("header does not carry stream bit");

  a_pilot_zeros: assert property (@(posedge clk_i) disable iff (srst_i)
    tx_valid_o && out_idx_ff >= 5'h1B && out_idx_ff <= 5'h1E
      |-> tx_block_o[1:0] == 2'h1)
    else $error("pilot zero missing");

  a_pilot_last: assert property (@(posedge clk_i) disable iff (srst_i)
    tx_valid_o && end_of_multiblock_pilot_o
      |-> out_idx_ff == 5'h1F && tx_block_o[1:0] == 2'h2)
    else $error("pilot one missing on last block");

  a_emb_flag: assert property (@(posedge clk_i) disable iff (srst_i)
    tx_valid_o && out_idx_ff == 5'h16
      |-> tx_block_o[1] == out_emb_flag_ff)
    else $error("extended multiblock flag wrong");

  a_crc_format: assert property (@(posedge clk_i) disable iff (srst_i)
    s_mb_end ##0 !fec_ff |=> stream_ff[3] && stream_ff[21]
      && !stream_ff[16] && !stream_ff[26])
    else $error("CRC fixed bits wrong");

  a_fec_format: assert property (@(posedge clk_i) disable iff (srst_i)
    s_mb_end ##0 fec_ff |=> stream_ff[31:27] == 5'h10)
    else $error("FEC pilot tail wrong");

  a_parity_clear: assert property (@(posedge clk_i) disable iff (srst_i)
    s_first_zero |=> par_ff == 26'h0000000)
    else $error("parity not cleared at multiblock start");

  a_mode_latch: assert property (@(posedge clk_i) disable iff (srst_i)
    s_mb_end |=> fec_ff == $past(sel_fec))
    else $error("format select not taken at boundary");

endmodule

// ===== testbench/rx_model.sv
// Far-side receiver model: takes coded blocks, rebuilds the sync
// header stream and divides the data for its own parity words.
// Assumes the generator's lane clock and the same realign pulse.
`timescale 1ns/1ps
module rx_model (
  input wire logic clk_i, // Lane block clock
  input wire logic srst_i, // Synchronous reset
  input wire logic emb_start_i, // Multiblock realign pulse
  input wire logic slow_i, // Refuse one cycle in four
  input wire logic tx_valid_i, // Coded block offered
  input wire logic [65:0] tx_block_i, // Header in [1:0]
  input wire logic pilot_i, // Last block marker
  output logic tx_ready_o // Block taken this cycle
);
  logic [31:0] sw_q[$];
  logic [11:0] crc_q[$];
  logic [25:0] fec_q[$];
  logic [63:0] data_q[$];
  logic [31:0] sw;
  logic [11:0] crc;
  logic [25:0] fec;
  logic fb;
  int bad_hdr;
  int bad_pilot;
  int bad_end_of_multiblock_pilot;
  int nblk;
  int cyc;

  // ----------------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------------
  // Ready moves only after a rising edge, as real logic would
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    tx_ready_o <= !(slow_i && cyc[1:0] == 2'h3);
  end

  // Take a block; generator terms below omit the top power
  always @(posedge clk_i)
  begin
    if (srst_i || emb_start_i)
    begin
      nblk = 0;
      crc = '0;
      fec = '0;
      if (srst_i)
      begin
        sw_q.delete();
        crc_q.delete();
        fec_q.delete();
        data_q.delete();
        bad_hdr = 0;
        bad_pilot = 0;
        bad_end_of_multiblock_pilot = 0;
      end
    end
    else if (tx_valid_i && tx_ready_o)
    begin
      if (tx_block_i[0] == tx_block_i[1])
        bad_hdr++;
      sw[nblk] = tx_block_i[1];
      data_q.push_back(tx_block_i[65:2]);
      for (int i = 0; i < 64; i++)
      begin
        fb = tx_block_i[2+i] ^ crc[11];
        crc = {crc[10:0], 1'b0} ^ (fb ? 12'h30F : 12'h000);
        fb = tx_block_i[2+i] ^ fec[25];
        fec = {fec[24:0], 1'b0} ^ (fb ? 26'h0220211 : 26'h0);
      end
      if (pilot_i !== (nblk == 31))
        bad_pilot++;
      if (nblk == 31)
      begin
        // Pilot must sit at the same tail position in every word
        if (sw[31:27] != 5'h10)
          bad_end_of_multiblock_pilot++;
        sw_q.push_back(sw);
        crc_q.push_back(crc);
        fec_q.push_back(fec);
        nblk = 0;
        crc = '0;
        fec = '0;
      end
      else
        nblk++;
    end
  end
endmodule

// ===== testbench/sync_header_stream_gen_test.sv
// Self-checking bench for the sync header stream generator.
// Assumes rx_model as the far side; inputs change on falling edges.
`timescale 1ns/1ps
module sync_header_stream_gen_test;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic blk_valid_i = 1'b0;
  logic [63:0] blk_data_i = '0;
  logic emb_start = 1'b0;
  logic [1:0] fmt = 2'h0;
  logic [7:0] emb_last = 8'h00;
  logic slow = 1'b0;
  logic blk_ready_o;
  logic tx_valid_o;
  logic [65:0] tx_block_o;
  logic tx_ready;
  logic pilot;
  int err_count = 0;
  int n_tests = 0;
  int nsent = 0;

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end

  // ----------------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------------
  // Half period of 25 ns gives 20 MHz
  always #25 clk_i = ~clk_i;

  sync_header_stream_gen sync_header_stream_gen_i (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .blk_valid_i(blk_valid_i),
    .blk_data_i(blk_data_i),
    .blk_ready_o(blk_ready_o),
    .local_extended_multiblock_clock_i(emb_start),
    .sync_header_format_select_i(fmt),
    .ext_mb_last_i(emb_last),
    .tx_valid_o(tx_valid_o),
    .tx_block_o(tx_block_o),
    .tx_ready_i(tx_ready),
    .end_of_multiblock_pilot_o(pilot)
  );

  rx_model rx_model_i (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .emb_start_i(emb_start),
    .slow_i(slow),
    .tx_valid_i(tx_valid_o),
    .tx_block_i(tx_block_o),
    .pilot_i(pilot),
    .tx_ready_o(tx_ready)
  );

  // ----------------------------------------------------------------------
  // Expected values
  // ----------------------------------------------------------------------
  function automatic logic [63:0] dat(input int i);
    // Block 0 of each multiblock is zero so the parity clear is exercised
    return (i % 32 == 0) ? 64'h0 :
      {i[31:0] ^ 32'hA5C3_0F1E, i[31:0] * 32'h0101_0101};
  endfunction

  // Parity fills the slots between the fixed ones, high bit first
  function automatic logic [31:0] crc_word(input logic [11:0] c,
    input logic e);
    int k;
    logic [31:0] w;
    k = 0;
    w = 32'h80A8_8888;
    for (int p = 0; p < 15; p++)
      if (p % 4 != 3)
      begin
        w[p] = c[11-k];
        k++;
      end
    w[22] = e;
    return w;
  endfunction

  function automatic logic [31:0] fec_word(input logic [25:0] f,
    input logic e);
    logic [31:0] w;
    w = 32'h8000_0000;
    for (int p = 0; p < 22; p++)
      w[p] = f[25-p];
    w[22] = e;
    w[23] = f[3];
    w[26:24] = {f[0], f[1], f[2]};
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Shared steps
  // ----------------------------------------------------------------------
  task automatic push_n(input int n);
    int w;
    for (int j = 0; j < n; j++)
    begin
      blk_data_i = dat(nsent);
      blk_valid_i = 1'b1;
      w = 0;
      while (blk_ready_o !== 1'b1 && w < 500)
      begin
        @(negedge clk_i);
        w++;
      end
      @(negedge clk_i);
      nsent++;
    end
    blk_valid_i = 1'b0;
  endtask

  task automatic start_mb(input logic [1:0] m, input int el, input logic s);
    fmt = m;
    emb_last = el[7:0];
    slow = s;
    emb_start = 1'b1;
    @(negedge clk_i);
    emb_start = 1'b0;
  endtask

  task automatic do_reset;
    srst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    srst_i = 1'b0;
    nsent = 0;
  endtask

  // Parity of multiblock k-1 rides in word k; word 0 carries zeros
  task automatic judge(input int nmb, input logic f, input int el);
    int w;
    logic e;
    w = 0;
    while (rx_model_i.sw_q.size() < nmb && w < 3000)
    begin
      @(negedge clk_i);
      w++;
    end
    `CHK(rx_model_i.sw_q.size(), nmb)
    for (int k = 0; k < nmb; k++)
    begin
      e = (k % (el + 1)) == el;
      `CHK(rx_model_i.sw_q[k][22], e)
      `CHK(rx_model_i.sw_q[k][31:27], 5'h10)
      if (f)
        `CHK(rx_model_i.sw_q[k], fec_word(k ? rx_model_i.fec_q[k-1] : '0, e))
      else
        `CHK(rx_model_i.sw_q[k], crc_word(k ? rx_model_i.crc_q[k-1] : '0, e))
    end
    for (int i = 0; i < nsent; i++)
      `CHK(rx_model_i.data_q[i], dat(i))
    `CHK(rx_model_i.bad_hdr, 0)
    `CHK(rx_model_i.bad_pilot, 0)
    `CHK(rx_model_i.bad_end_of_multiblock_pilot, 0)
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Fill the buffer while output waits, then drain with a stalling sink
  task automatic t_fill_crc;
    int n;
    n = 0;
    blk_data_i = dat(0);
    blk_valid_i = 1'b1;
    repeat (60)
    begin
      if (blk_ready_o === 1'b1)
        n++;
      @(negedge clk_i);
      blk_data_i = dat(n);
    end
    blk_valid_i = 1'b0;
    nsent = n;
    `CHK(n, 33)
    start_mb(2'h0, 0, 1'b1);
    push_n(96 - n);
    judge(3, 1'b0, 0);
    $display("test fill_crc done");
  endtask

  // FEC words with three multiblocks per extended multiblock
  task automatic t_fec;
    do_reset();
    start_mb(2'h2, 2, 1'b0);
    push_n(128);
    judge(4, 1'b1, 2);
    $display("test fec done");
  endtask

  // Undocumented select codes fall back to the CRC-12 layout
  task automatic t_other;
    for (int m = 1; m < 4; m += 2)
    begin
      do_reset();
      start_mb(m[1:0], 1, 1'b1);
      push_n(64);
      judge(2, 1'b0, 1);
    end
    $display("test other_codes done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run is about five hundred cycles; the limit leaves wide margin
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end

  // Main sequence after 20 cycles of reset
  initial
  begin
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    t_fill_crc();
    t_fec();
    t_other();
    test_done();
  end
endmodule
